// File: verilog/fp_save_pkg.sv
// Constants for the floating-point stack state image block
package fp_save_pkg;
	localparam int NUM_REGS = 8;
	localparam int REG_W = 80;
	localparam int WORD_W = 16;
	localparam int OPC_W = 11;
	localparam int IMG_WORDS = 27;
	localparam int ENV_WORDS = 7;
	localparam logic [6:0] OFS_CW = 7'h00;
	localparam logic [6:0] OFS_SW = 7'h04;
	localparam logic [6:0] OFS_TW = 7'h08;
	localparam logic [6:0] OFS_IP = 7'h0c;
	localparam logic [6:0] OFS_OPC = 7'h10;
	localparam logic [6:0] OFS_DP = 7'h14;
	localparam logic [6:0] OFS_DPX = 7'h18;
	localparam logic [6:0] OFS_DATA = 7'h1c;
	localparam logic [6:0] IMG_BYTES = 7'h6c;
	localparam int TOP_LSB = 11;
	localparam logic [15:0] TAGS_EMPTY = 16'hffff;
	localparam logic [15:0] CW_RESET = 16'h037f;
	localparam logic [15:0] SW_RESET = 16'h0000;
	localparam logic [15:0] TW_RESET = 16'hffff;
	localparam logic [4:0] LAST_WORD = 5'h1a;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXC_WAIT,
		ST_WRITE,
		ST_READ,
		ST_UNPACK
	} op_state_t;
endpackage

// File: verilog/fp_stack_state_save_image.sv
// Floating-point stack register state and its 32-bit save/restore memory image
`timescale 1ns/10ps
`default_nettype none

module fp_stack_state_save_image (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic prot_mode,
	input wire logic ins_commit,
	input wire logic ins_noncontrol,
	input wire logic ins_mem_access,
	input wire logic [7:0] opc_byte0,
	input wire logic [7:0] opc_byte1,
	input wire logic [31:0] ins_offset,
	input wire logic [15:0] ins_selector,
	input wire logic [31:0] data_offset,
	input wire logic [15:0] data_selector,
	input wire logic cw_wr,
	input wire logic sw_wr,
	input wire logic [15:0] word_wdata,
	input wire logic data_wr,
	input wire logic [2:0] data_wr_idx,
	input wire logic [79:0] data_wdata,
	input wire logic [2:0] data_rd_idx,
	output logic [79:0] data_rdata,
	output logic [15:0] fp_control_word,
	output logic [15:0] fp_status_word,
	output logic [15:0] fp_tag_word,
	output logic [10:0] last_opcode_record,
	input wire logic checked_state_store,
	input wire logic unchecked_state_store,
	input wire logic state_image_load,
	input wire logic exc_pending,
	output logic exc_req,
	input wire logic exc_done,
	output logic busy,
	output logic op_done,
	output logic mem_valid,
	output logic mem_write,
	output logic [6:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ready
);
	logic [79:0] stack_data_regs_r [fp_save_pkg::NUM_REGS];
	logic [15:0] cw_r, sw_r, tw_r;
	logic [10:0] opc_r;
	logic [31:0] ip_off_r, dp_off_r;
	logic [15:0] ip_sel_r, dp_sel_r;
	logic [31:0] img_r [fp_save_pkg::IMG_WORDS];
	fp_save_pkg::op_state_t state_r;
	logic [4:0] word_r;
	logic prot_r;
	logic [2:0] top;
	logic [639:0] stk_vec;
	logic [639:0] img_data;
	logic [31:0] out_word;
	logic beat;
	logic last_beat;

	// State views and bus strobes from the registers; beat and last_beat also take mem_ready
	assign top = sw_r[fp_save_pkg::TOP_LSB +: 3];
	assign beat = mem_valid && mem_ready;
	assign last_beat = beat && (word_r == fp_save_pkg::LAST_WORD);
	assign busy = (state_r != fp_save_pkg::ST_IDLE);
	assign exc_req = (state_r == fp_save_pkg::ST_EXC_WAIT);
	assign mem_valid = (state_r == fp_save_pkg::ST_WRITE) || (state_r == fp_save_pkg::ST_READ);
	assign mem_write = (state_r == fp_save_pkg::ST_WRITE);
	assign mem_addr = {word_r, 2'b00};
	assign mem_wdata = out_word;
	assign fp_control_word = cw_r;
	assign fp_status_word = sw_r;
	assign fp_tag_word = tw_r;
	assign last_opcode_record = opc_r;
	assign data_rdata = stack_data_regs_r[data_rd_idx];

	// Stack-order view of the data registers, top of stack first
	always_comb begin
		for (int i = 0; i < fp_save_pkg::NUM_REGS; i++) begin
			stk_vec[80*i +: 80] = stack_data_regs_r[3'(top + 3'(i))];
		end
	end

	// Data area of a loaded image, words 7..26 flattened
	always_comb begin
		for (int k = 0; k < fp_save_pkg::IMG_WORDS - fp_save_pkg::ENV_WORDS; k++) begin
			img_data[32*k +: 32] = img_r[k + fp_save_pkg::ENV_WORDS];
		end
	end

	// Outgoing image word; reserved fields are written as zero
	always_comb begin
		out_word = 32'h0000_0000;
		if ({word_r, 2'b00} == fp_save_pkg::OFS_CW) begin
			out_word = {16'h0000, cw_r};
		end else if ({word_r, 2'b00} == fp_save_pkg::OFS_SW) begin
			out_word = {16'h0000, sw_r};
		end else if ({word_r, 2'b00} == fp_save_pkg::OFS_TW) begin
			out_word = {16'h0000, tw_r};
		end else if ({word_r, 2'b00} == fp_save_pkg::OFS_IP) begin
			out_word = prot_r ? ip_off_r : {16'h0000, ip_off_r[15:0]};
		end else if ({word_r, 2'b00} == fp_save_pkg::OFS_OPC) begin
			out_word = prot_r ? {5'h00, opc_r, ip_sel_r} : {4'h0, ip_off_r[31:16], 1'b0, opc_r};
		end else if ({word_r, 2'b00} == fp_save_pkg::OFS_DP) begin
			out_word = prot_r ? dp_off_r : {16'h0000, dp_off_r[15:0]};
		end else if ({word_r, 2'b00} == fp_save_pkg::OFS_DPX) begin
			out_word = prot_r ? {16'h0000, dp_sel_r} : {4'h0, dp_off_r[31:16], 12'h000};
		end else if ({word_r, 2'b00} >= fp_save_pkg::OFS_DATA) begin
			out_word = stk_vec[32*(word_r - 5'(fp_save_pkg::ENV_WORDS)) +: 32];
		end
	end

	// Operation sequencer; only the x87 image is moved, never media state
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_r <= fp_save_pkg::ST_IDLE;
		end else begin
			case (state_r)
				fp_save_pkg::ST_IDLE: begin
					if (checked_state_store) begin
						state_r <= exc_pending ? fp_save_pkg::ST_EXC_WAIT : fp_save_pkg::ST_WRITE;
					end else if (unchecked_state_store) begin
						state_r <= fp_save_pkg::ST_WRITE;
					end else if (state_image_load) begin
						state_r <= fp_save_pkg::ST_READ;
					end
				end
				fp_save_pkg::ST_EXC_WAIT: begin
					if (exc_done) begin
						state_r <= fp_save_pkg::ST_WRITE;
					end
				end
				fp_save_pkg::ST_WRITE: begin
					if (last_beat) begin
						state_r <= fp_save_pkg::ST_IDLE;
					end
				end
				fp_save_pkg::ST_READ: begin
					if (last_beat) begin
						state_r <= fp_save_pkg::ST_UNPACK;
					end
				end
				fp_save_pkg::ST_UNPACK: begin
					state_r <= fp_save_pkg::ST_IDLE;
				end
				default: begin
					state_r <= fp_save_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Word counter and layout latch; one latch serves store and restore alike
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			word_r <= 5'h00;
			prot_r <= 1'b1;
		end else if (state_r == fp_save_pkg::ST_IDLE) begin
			word_r <= 5'h00;
			if (checked_state_store || unchecked_state_store || state_image_load) begin
				prot_r <= prot_mode;
			end
		end else if (beat) begin
			word_r <= last_beat ? 5'h00 : word_r + 5'h01;
		end
	end

	// Completion pulse for the core
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			op_done <= 1'b0;
		end else begin
			op_done <= (state_r == fp_save_pkg::ST_UNPACK) ||
				(state_r == fp_save_pkg::ST_WRITE && last_beat);
		end
	end

	// Capture buffer for an incoming image
	always_ff @(posedge clock) begin
		if (state_r == fp_save_pkg::ST_READ && beat) begin
			img_r[word_r] <= mem_rdata;
		end
	end

	// Physical data registers; software writes are held off while busy
	always_ff @(posedge clock) begin
		if (state_r == fp_save_pkg::ST_UNPACK) begin
			for (int i = 0; i < fp_save_pkg::NUM_REGS; i++) begin
				stack_data_regs_r[3'(img_r[1][13:11] + 3'(i))] <= img_data[80*i +: 80];
			end
		end else if (data_wr && !busy) begin
			stack_data_regs_r[data_wr_idx] <= data_wdata;
		end
	end

	// Control, status and tag words
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cw_r <= fp_save_pkg::CW_RESET;
			sw_r <= fp_save_pkg::SW_RESET;
			tw_r <= fp_save_pkg::TW_RESET;
		end else if (state_r == fp_save_pkg::ST_UNPACK) begin
			cw_r <= img_r[0][15:0];
			sw_r <= img_r[1][15:0];
			tw_r <= img_r[2][15:0];
		end else if (state_r == fp_save_pkg::ST_WRITE && last_beat) begin
			tw_r <= fp_save_pkg::TAGS_EMPTY;
		end else if (!busy) begin
			if (cw_wr) begin
				cw_r <= word_wdata;
			end
			if (sw_wr) begin
				sw_r <= word_wdata;
			end
			if (data_wr) begin
				tw_r[2*data_wr_idx +: 2] <= 2'b00;
			end
		end
	end

	// Last-instruction and last-data pointers and opcode, kept by hardware
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			opc_r <= 11'h000;
			ip_off_r <= 32'h0000_0000;
			ip_sel_r <= 16'h0000;
			dp_off_r <= 32'h0000_0000;
			dp_sel_r <= 16'h0000;
		end else if (state_r == fp_save_pkg::ST_UNPACK) begin
			if (prot_r) begin
				ip_off_r <= img_r[3];
				ip_sel_r <= img_r[4][15:0];
				opc_r <= img_r[4][26:16];
				dp_off_r <= img_r[5];
				dp_sel_r <= img_r[6][15:0];
			end else begin
				ip_off_r <= {img_r[4][27:12], img_r[3][15:0]};
				ip_sel_r <= 16'h0000; // No selectors in the real-mode image
				opc_r <= img_r[4][10:0];
				dp_off_r <= {img_r[6][27:12], img_r[5][15:0]};
				dp_sel_r <= 16'h0000;
			end
		end else if (ins_commit && ins_noncontrol && !busy) begin
			opc_r <= {opc_byte0[2:0], opc_byte1};
			ip_off_r <= ins_offset;
			ip_sel_r <= ins_selector;
			if (ins_mem_access) begin
				dp_off_r <= data_offset;
				dp_sel_r <= data_selector;
			end
		end
	end

	opcode_form_a: assert property (@(posedge clock) disable iff (!rst_b)
		ins_commit && ins_noncontrol && !busy |=> opc_r == {$past(opc_byte0[2:0]), $past(opc_byte1)})
		else $error("opcode record not formed from opcode bytes");
	tag_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
		state_r == fp_save_pkg::ST_WRITE && last_beat |=> tw_r == 16'hffff && op_done)
		else $error("tags not emptied after store");
	unchecked_skip_a: assert property (@(posedge clock) disable iff (!rst_b)
		!busy && unchecked_state_store && !checked_state_store |=> mem_valid && mem_write && !exc_req)
		else $error("unchecked store did not write at once");
	checked_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
		exc_req && !exc_done |=> exc_req && !mem_valid)
		else $error("checked store wrote before exception handled");
	checked_entry_a: assert property (@(posedge clock) disable iff (!rst_b)
		!busy && checked_state_store && exc_pending |=> exc_req)
		else $error("pending exception not raised before store");
	status_slot_a: assert property (@(posedge clock) disable iff (!rst_b)
		mem_write && mem_addr == 7'h04 |-> mem_wdata == {16'h0000, sw_r})
		else $error("status word not at offset 04h");
	data_ptr_a: assert property (@(posedge clock) disable iff (!rst_b)
		mem_write && mem_addr == 7'h14 && prot_r |-> mem_wdata == dp_off_r)
		else $error("protected data offset misplaced");
	real_ptr_a: assert property (@(posedge clock) disable iff (!rst_b)
		mem_write && mem_addr == 7'h18 && !prot_r |-> mem_wdata[27:12] == dp_off_r[31:16])
		else $error("real-mode high data offset misplaced");
	top_slot_a: assert property (@(posedge clock) disable iff (!rst_b)
		mem_write && mem_addr == 7'h1c |-> mem_wdata == stack_data_regs_r[top][31:0])
		else $error("image data does not start at top of stack");
	addr_step_a: assert property (@(posedge clock) disable iff (!rst_b)
		beat && !last_beat |=> mem_valid && mem_addr == $past(mem_addr) + 7'h04)
		else $error("image words skipped");
	layout_keep_a: assert property (@(posedge clock) disable iff (!rst_b)
		busy && $past(busy) |-> prot_r == $past(prot_r))
		else $error("layout changed mid-operation");
endmodule // fp_stack_state_save_image

`default_nettype wire

// File: tb/image_mem_model.sv
// Behavioural memory that receives and returns the state image
`timescale 1ns/10ps
`default_nettype none
module image_mem_model (
	input wire logic clock,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [6:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ready
);
	logic [31:0] words [27];
	logic [31:0] last_rd = 32'h0;
	logic rdy_r = 1'b0;
	// One process owns ready; the port only mirrors it
	assign mem_ready = rdy_r;
	// Ready drops about one beat in four, so the block must hold its request
	always @(posedge clock) begin
		if (mem_valid && mem_ready && mem_write) words[mem_addr[6:2]] <= mem_wdata;
		if (mem_valid && mem_ready && !mem_write) last_rd <= mem_rdata;
		rdy_r <= ($urandom % 4) != 0;
	end
	// An idle read bus shows the inverse of the last word, never a stale copy
	assign mem_rdata = (mem_valid && !mem_write) ? words[mem_addr[6:2]] : ~last_rd;
endmodule // image_mem_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the stack state image block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clock = 1'b0, rst_b = 1'b0, prot_mode = 1'b0, ins_commit = 1'b0, ins_noncontrol = 1'b0;
	logic ins_mem_access = 1'b0, cw_wr = 1'b0, sw_wr = 1'b0, data_wr = 1'b0, exc_pending = 1'b0;
	logic checked_state_store = 1'b0, unchecked_state_store = 1'b0, state_image_load = 1'b0;
	logic exc_done = 1'b0, exc_req, busy, op_done, mem_valid, mem_write, mem_ready;
	logic [7:0] opc_byte0 = 8'h0, opc_byte1 = 8'h0;
	logic [31:0] ins_offset = 32'h0, data_offset = 32'h0, mem_wdata, mem_rdata, ipo, dpo;
	logic [15:0] ins_selector = 16'h0, data_selector = 16'h0, word_wdata = 16'h0;
	logic [2:0] data_wr_idx = 3'h0, data_rd_idx = 3'h0;
	logic [79:0] data_wdata = 80'h0, data_rdata;
	logic [15:0] fp_control_word, fp_status_word, fp_tag_word, cw_m, sw_m, tw_m, ips, dps;
	logic [10:0] last_opcode_record, opc_m;
	logic [6:0] mem_addr;
	logic [38:0] exp_q [$];
	logic [79:0] phys [8];
	int n_errors = 0, check_count = 0;

	fp_stack_state_save_image DUT (.clock, .rst_b, .prot_mode, .ins_commit, .ins_noncontrol,
		.ins_mem_access, .opc_byte0, .opc_byte1, .ins_offset, .ins_selector, .data_offset,
		.data_selector, .cw_wr, .sw_wr, .word_wdata, .data_wr, .data_wr_idx, .data_wdata,
		.data_rd_idx, .data_rdata, .fp_control_word, .fp_status_word, .fp_tag_word,
		.last_opcode_record, .checked_state_store, .unchecked_state_store, .state_image_load,
		.exc_pending, .exc_req, .exc_done, .busy, .op_done, .mem_valid, .mem_write, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ready);
	image_mem_model u_mem (.clock, .mem_valid, .mem_write, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ready);

	always #50 clock = ~clock;

	task automatic step();
		@(posedge clock);
		#10;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step();
		s = 1'b0;
	endtask
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Expected image words, in beat order, from the bench's own copy of the state
	task automatic push_image(input logic prot);
		logic [639:0] d;
		logic [31:0] w [27];
		for (int i = 0; i < 8; i++) d[i*80 +: 80] = phys[3'(sw_m[13:11] + 3'(i))];
		w[0] = {16'h0, cw_m};
		w[1] = {16'h0, sw_m};
		w[2] = {16'h0, tw_m};
		w[3] = prot ? ipo : {16'h0, ipo[15:0]};
		w[4] = prot ? {5'h0, opc_m, ips} : {4'h0, ipo[31:16], 1'b0, opc_m};
		w[5] = prot ? dpo : {16'h0, dpo[15:0]};
		w[6] = prot ? {16'h0, dps} : {4'h0, dpo[31:16], 12'h0};
		for (int k = 7; k < 27; k++) w[k] = d[(k-7)*32 +: 32];
		for (int k = 0; k < 27; k++) exp_q.push_back({7'(k*4), w[k]});
	endtask
	// Bounded wait for the one-cycle completion pulse
	task automatic wait_done();
		int n = 0;
		while (op_done !== 1'b1 && n < 400) begin
			step();
			n++;
		end
		if (n == 400) n_errors++;
		check(80'(exp_q.size()), 80'h0);
		check(80'(busy), 80'h0);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Every accepted write beat is matched against the oldest noted word
	always @(posedge clock) begin
		if (rst_b && mem_valid && mem_ready && mem_write) begin
			if (exp_q.size() == 0) check(80'h1, 80'h0);
			else check(80'({mem_addr, mem_wdata}), 80'(exp_q.pop_front()));
		end
	end

	initial begin
		#(100 * 3000);
		n_errors++;
		finish_test();
	end

	initial begin
		void'($urandom(32'h894614db));
		step();
		step();
		rst_b = 1'b1;
		check(80'(fp_control_word), 80'(fp_save_pkg::CW_RESET));
		check(80'(fp_tag_word), 80'(fp_save_pkg::TW_RESET));
		cw_m = 16'($urandom);
		sw_m = 16'($urandom);
		word_wdata = cw_m;
		pulse(cw_wr);
		word_wdata = sw_m;
		pulse(sw_wr);
		for (int i = 0; i < 8; i++) begin
			phys[i] = {$urandom, $urandom, 16'($urandom)};
			data_wr_idx = 3'(i);
			data_wdata = phys[i];
			pulse(data_wr);
		end
		tw_m = 16'h0;
		check(80'(fp_status_word), 80'(sw_m));
		check(80'(fp_tag_word), 80'(tw_m));
		ipo = $urandom;
		dpo = $urandom;
		ips = 16'($urandom);
		dps = 16'($urandom);
		{ins_offset, data_offset, ins_selector, data_selector} = {ipo, dpo, ips, dps};
		{opc_byte0, opc_byte1, ins_noncontrol, ins_mem_access} = {16'hd9f8, 2'b11};
		pulse(ins_commit);
		check(80'(last_opcode_record), 80'h1f8);
		// A control instruction must leave the record alone
		{ins_noncontrol, opc_byte0, ins_offset} = {1'b0, 8'hdb, ~ipo};
		pulse(ins_commit);
		check(80'(last_opcode_record), 80'h1f8);
		// No memory operand: data pointer keeps its earlier value
		ipo = ipo + 32'h4;
		{ins_noncontrol, ins_mem_access, ins_offset} = {2'b10, ipo};
		{opc_byte0, opc_byte1, data_offset, data_selector} = {16'hdec1, ~dpo, ~dps};
		pulse(ins_commit);
		opc_m = 11'h6c1;
		prot_mode = 1'b1;
		exc_pending = 1'b1;
		push_image(1'b1);
		pulse(unchecked_state_store);
		check(80'(exc_req), 80'h0);
		check(80'(busy), 80'h1);
		word_wdata = ~cw_m;
		pulse(cw_wr);
		wait_done();
		tw_m = 16'hffff;
		check(80'(fp_tag_word), 80'(tw_m));
		prot_mode = 1'b0;
		push_image(1'b0);
		pulse(checked_state_store);
		repeat (3) begin
			check(80'(exc_req), 80'h1);
			check(80'(mem_valid), 80'h0);
			step();
		end
		exc_pending = 1'b0;
		pulse(exc_done);
		wait_done();
		cw_m = ~cw_m;
		u_mem.words[0] = {16'h0, cw_m};
		pulse(state_image_load);
		wait_done();
		check(80'(fp_control_word), 80'(cw_m));
		for (int i = 0; i < 8; i++) begin
			data_rd_idx = 3'(i);
			step();
			check(data_rdata, phys[i]);
		end
		// Real-mode restore has no selectors, so a protected store shows zeros
		{ips, dps, prot_mode} = {32'h0, 1'b1};
		push_image(1'b1);
		pulse(unchecked_state_store);
		wait_done();
		// Checked store with nothing pending writes at once
		push_image(1'b1);
		pulse(checked_state_store);
		check(80'(exc_req), 80'h0);
		check(80'(mem_valid), 80'h1);
		wait_done();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
